// File: hdl/brps_sequencer.v
// Boot, reset and low-power sequencer
`timescale 1ns/1ps
`include "brps_map.vh"
module brps_sequencer #(
  parameter RATIO_W = 7
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        clk_en,
  input  wire        boot_select_bit2,
  input  wire        boot_select_bit1,
  input  wire        boot_select_bit0,
  input  wire        soft_reset_write,
  input  wire [15:0] clock_control_register,
  input  wire        idle_exec,
  input  wire        wake_irq,
  output reg  [2:0]  boot_code,
  output reg         boot_code_valid,
  output reg         boot_irq,
  output reg  [23:0] fetch_addr,
  output reg         fetch_load,
  output reg         core_rst,
  output reg         core_clk_en,
  output reg         periph_clk_en,
  output reg         pll_clk_en,
  output reg  [RATIO_W-1:0] clk_ratio,
  output reg         wake_ack
);
  // ----------------------------------------
  // Low-power state, one-hot
  // ----------------------------------------
  localparam [4:0] ST_RUN  = 5'h01;
  localparam [4:0] ST_IDL  = 5'h02;
  localparam [4:0] ST_PDC  = 5'h04;
  localparam [4:0] ST_PDP  = 5'h08;
  localparam [4:0] ST_PDA  = 5'h10;
  reg [4:0] state;
  reg [4:0] next_state;
  reg                boot_pend;
  reg                captured;
  reg                next_boot_pend;
  reg                next_wake_ack;
  reg                boot_now;
  wire [2:0]         strap_code;
  wire [2:0]         next_grp_en;
  wire [1:0]         lp_mode;
  wire [RATIO_W-1:0] ratio_field;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function [4:0] mode_state;
    input [1:0] m;
    begin
      case (m)
        `BRPS_MODE_IDLE:    mode_state = ST_IDL;
        `BRPS_MODE_PD_CORE: mode_state = ST_PDC;
        `BRPS_MODE_PD_CPER: mode_state = ST_PDP;
        default:            mode_state = ST_PDA;
      endcase
    end
  endfunction

  function valid_code;
    input [2:0] c;
    begin
      // Codes at or above the count of valid selections are reserved
      valid_code = (c < `BRPS_BOOT_VALID);
    end
  endfunction

  // Group 0 is the core, 1 the peripherals, 2 the clock multiplier
  function group_runs;
    input [4:0] s;
    input [1:0] g;
    begin
      case (g)
        2'h0:    group_runs = (s == ST_RUN);
        2'h1:    group_runs = !(s == ST_PDP || s == ST_PDA);
        2'h2:    group_runs = (s != ST_PDA);
        default: group_runs = 1'b1;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Input fields
  // ----------------------------------------
  assign strap_code  = {boot_select_bit2, boot_select_bit1, boot_select_bit0};
  assign lp_mode     = clock_control_register[`BRPS_CTL_MODE_LSB +: 2];
  assign ratio_field = clock_control_register[`BRPS_CTL_RATIO_LSB +: RATIO_W];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // A software reset outranks everything; the boot request outranks idle,
  // so an idle in the boot cycle is dropped rather than queued.
  always @* begin
    next_state     = state;
    next_boot_pend = boot_pend;
    next_wake_ack  = 1'b0;
    boot_now       = 1'b0;
    if (soft_reset_write) begin
      next_boot_pend = 1'b1;
      next_state     = ST_RUN;
    end else if (boot_pend) begin
      // No mask input exists: the boot request always fires
      next_boot_pend = 1'b0;
      boot_now       = 1'b1;
      next_state     = ST_RUN;
    end else begin
      case (state)
        ST_RUN: begin
          if (idle_exec) begin
            next_state = mode_state(lp_mode);
          end
        end
        ST_IDL, ST_PDC, ST_PDP, ST_PDA: begin
          if (wake_irq) begin
            next_state    = ST_RUN;
            next_wake_ack = 1'b1;
          end
        end
        default: begin
          next_state = ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Clock group enables
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_grp
      localparam [1:0] GIDX = g;
      assign next_grp_en[g] = group_runs(next_state, GIDX);
    end
  endgenerate

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // Straps cannot be loaded under async reset, so the first enabled edge
  // after release captures them; the pins must stay static around reset.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      captured        <= 1'b0;
      boot_code       <= 3'h0;
      boot_code_valid <= 1'b0;
    end else if (clk_en) begin
      if (!captured) begin
        captured        <= 1'b1;
        boot_code       <= strap_code;
        boot_code_valid <= valid_code(strap_code);
      end
    end
  end

  // ----------------------------------------
  // State and boot request
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ST_RUN;
      boot_pend <= 1'b1;
    end else if (clk_en) begin
      state     <= next_state;
      boot_pend <= next_boot_pend;
    end
  end

  // ----------------------------------------
  // Boot outputs
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_irq   <= 1'b0;
      fetch_addr <= `BRPS_BOOT_VECTOR;
      fetch_load <= 1'b0;
      core_rst   <= 1'b1;
    end else if (clk_en) begin
      boot_irq   <= boot_now;
      fetch_load <= boot_now;
      if (boot_now) begin
        fetch_addr <= `BRPS_BOOT_VECTOR;
      end
      // Core stays in reset for the cycle after the write, then boots
      core_rst   <= soft_reset_write;
    end
  end

  // ----------------------------------------
  // Clock enables and wake acknowledge
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_clk_en   <= 1'b1;
      periph_clk_en <= 1'b1;
      pll_clk_en    <= 1'b1;
      wake_ack      <= 1'b0;
    end else if (clk_en) begin
      core_clk_en   <= next_grp_en[0];
      periph_clk_en <= next_grp_en[1];
      pll_clk_en    <= next_grp_en[2];
      wake_ack      <= next_wake_ack;
    end
  end

  // ----------------------------------------
  // Clock ratio
  // ----------------------------------------
  // The ratio is only copied here; the multiplier itself sits outside,
  // so a ratio change takes effect one enabled cycle after the write.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_ratio <= {RATIO_W{1'b0}};
    end else if (clk_en) begin
      clk_ratio <= ratio_field;
    end
  end
endmodule // brps_sequencer

// File: hdl/brps_map.vh
// Constants for the boot, reset and power sequencer
// What this block does
// - Capture three boot pins on the first enabled edge after hardware reset
// - Nonmaskable boot interrupt vectors to 0xFF0000
// - Boot interrupt follows hardware or software reset
// - Fetch always starts at 0xFF0000 after reset
// - Idle enters mode chosen by control bits
// - Four modes gate clock groups; idle and core power-down both gate only the core
// - Multiplier 1x to 32x, 128 ratios
`ifndef BRPS_MAP_VH
`define BRPS_MAP_VH
`define BRPS_BOOT_VECTOR    24'hff0000
`define BRPS_MODE_IDLE      2'h0
`define BRPS_MODE_PD_CORE   2'h1
`define BRPS_MODE_PD_CPER   2'h2
`define BRPS_MODE_PD_ALL    2'h3
`define BRPS_CTL_MODE_LSB   8
`define BRPS_CTL_RATIO_LSB  0
`define BRPS_CTL_RESET      16'h0000
`define BRPS_BOOT_CODES     8
`define BRPS_BOOT_VALID     5
`endif

// File: verif/brps_strap_model.sv
// Strap pin model for the sequencer
`timescale 1ns/1ps
module brps_strap_model(input wire [2:0] c,output wire boot_select_bit2,
  output wire boot_select_bit1,output wire boot_select_bit0);
  // Straps are static levels, held steady across the whole reset
  assign {boot_select_bit2,boot_select_bit1,boot_select_bit0}=c;
endmodule // brps_strap_model

// File: verif/brps_properties.sv
// Sequencer checker
`timescale 1ns/1ps
module brps_properties #(parameter RATIO_W=7)(input wire clk,arst_n,clk_en,soft_reset_write,
  input wire idle_exec,wake_irq,wake_ack,boot_irq,fetch_load,core_rst,core_clk_en,
  input wire periph_clk_en,pll_clk_en,boot_code_valid,input wire [2:0] boot_code,
  input wire [23:0] fetch_addr,input wire [15:0] clock_control_register,
  input wire [RATIO_W-1:0] clk_ratio);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Idle only counts in run, outside the cycle in which boot_irq is high
  wire go=idle_exec&core_clk_en&pll_clk_en&~boot_irq&clk_en;
  wire [1:0] md=clock_control_register[9:8];
  property p_v; fetch_load|->boot_code_valid==(boot_code<3'h5); endproperty
  a_v: assert property(p_v) else $error("valid");
  property p_f; fetch_addr==24'hff0000&&fetch_load==boot_irq; endproperty
  a_f: assert property(p_f) else $error("vector");
  property p_s; soft_reset_write&&clk_en|=>core_rst##1 boot_irq; endproperty
  a_s: assert property(p_s) else $error("soft");
  property p_i; go|=>!core_clk_en; endproperty
  a_i: assert property(p_i) else $error("idle");
  property p_a; go&&md==2'h3|=>!periph_clk_en&&!pll_clk_en; endproperty
  a_a: assert property(p_a) else $error("all");
  property p_c; go&&md==2'h1|=>(periph_clk_en&&!core_clk_en)[*2]; endproperty
  a_c: assert property(p_c) else $error("core");
  property p_r; $past(arst_n)&&$past(clk_en)|->clk_ratio==$past(clock_control_register[6:0]);
  endproperty
  a_r: assert property(p_r) else $error("ratio");
  property p_w; wake_irq&&!core_clk_en&&clk_en|=>wake_ack&&core_clk_en; endproperty
  a_w: assert property(p_w) else $error("wake");
endmodule // brps_properties
bind brps_sequencer brps_properties #(.RATIO_W(RATIO_W)) brps_properties_inst(.*);

// File: verif/test_brps_sequencer.sv
// Sequencer bench
`timescale 1ns/1ps
module test_brps_sequencer;
  logic clk=0,arst_n=0,clk_en=1,soft_reset_write=0,idle_exec=0,wake_irq=0;
  logic [2:0] c=0;
  logic [15:0] clock_control_register=0;
  wire [2:0] boot_code;
  wire [23:0] fetch_addr;
  wire [6:0] clk_ratio;
  wire boot_select_bit2,boot_select_bit1,boot_select_bit0,boot_code_valid,boot_irq,fetch_load;
  wire core_rst,core_clk_en,periph_clk_en,pll_clk_en,wake_ack;
  int fails=0,total_checks=0,i;
  brps_strap_model brps_strap_model_inst(.*);
  brps_sequencer brps_sequencer_inst(.*);
  initial forever #10 clk=~clk;
  function logic [2:0] en(logic [1:0] m);
    return {1'h0,m<2'h2,m!=2'h3};
  endfunction
  task chk(input logic [31:0] g,x);
    total_checks++;
    if(g!==x) fails++;
    if(g!==x) $display("CHECK FAILED %0t seen %h",$time,g);
  endtask
  task tally_and_finish;
    $display("checks %0d fails %0d",total_checks,fails);
    if(fails==0&&total_checks>0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(1377));
    // Every strap code and every mode, then random codes; ratios random throughout
    for(i=0;i<12;i++) begin
      c<=3'(i<8?i:$urandom);
      clock_control_register<={6'h0,2'(i),1'h0,7'($urandom)};
      repeat(6) @(posedge clk);
      arst_n<=1;
      @(posedge clk) soft_reset_write<=1;
      #1 chk({boot_irq,boot_code,boot_code_valid},{1'h1,c,c<3'h5});
      @(posedge clk) soft_reset_write<=0;
      @(posedge clk) #1 chk({boot_irq,fetch_addr},{1'h1,24'hff0000});
      repeat(2) @(posedge clk);
      idle_exec<=1;
      @(posedge clk) idle_exec<=0;
      #1 chk({core_clk_en,periph_clk_en,pll_clk_en},en(clock_control_register[9:8]));
      @(posedge clk) wake_irq<=1;
      @(posedge clk) wake_irq<=0;
      #1 chk({wake_ack,core_clk_en,clk_ratio},{2'h3,clock_control_register[6:0]});
      // Frozen by the clock enable: idle and a new ratio must not take
      @(posedge clk) begin
        clk_en<=0;
        idle_exec<=1;
        clock_control_register<=clock_control_register^16'h007f;
      end
      repeat(2) @(posedge clk);
      #1 chk({core_clk_en,clk_ratio},{1'h1,clock_control_register[6:0]^7'h7f});
      @(posedge clk) begin
        clk_en<=1;
        idle_exec<=0;
      end
      @(posedge clk) #1 chk(clk_ratio,clock_control_register[6:0]);
      @(posedge clk) arst_n<=0;
    end
    tally_and_finish;
  end
  initial begin
    #40us;
    fails++;
    tally_and_finish;
  end
endmodule // test_brps_sequencer
